// ==== rtl/ptu_defs.svh ====
// Register map, field positions and reset values of the pulse timer unit
`ifndef PTU_DEFS_SVH
`define PTU_DEFS_SVH
`define PTU_NCH 2
`define PTU_AXI_AW 8
`define PTU_OFS_SC 8'h00
`define PTU_OFS_CNT 8'h04
`define PTU_OFS_MOD 8'h08
`define PTU_OFS_SOPT 8'h0C
`define PTU_OFS_CH0SC 8'h10
`define PTU_OFS_CH0V 8'h14
`define PTU_CH_STRIDE 8
`define PTU_OFS_ISTAT 8'h20
`define PTU_OFS_IMASK 8'h24
`define PTU_SC_OVF 7
`define PTU_SC_CENTER_ALIGNED_PWM 5
`define PTU_SC_CLK_HI 4
`define PTU_SC_CLK_LO 3
`define PTU_SC_PS_HI 2
`define PTU_CH_FLAG 7
`define PTU_CH_MODE_HI 5
`define PTU_CH_MODE_LO 4
`define PTU_CH_EDGE_HI 3
`define PTU_CH_EDGE_LO 2
`define PTU_INT_OVF 2
`define PTU_INT_W 3
`define PTU_SC_RST 6'h00
`define PTU_CH_RST 6'h00
`define PTU_CNT_RST 16'h0000
`define PTU_MOD_RST 16'h0000
`define PTU_FULL_RANGE 16'hFFFF
`define PTU_INT_RST 3'h0
`define PTU_RESP_OKAY 2'h0
`define PTU_RESP_SLVERR 2'h2
`endif

// ==== rtl/ptu_pkg.sv ====
// Types shared by the pulse timer unit modules
package ptu_pkg;
  typedef enum logic [1:0] {
    PTU_CLK_OFF = 2'h0,
    PTU_CLK_BUS = 2'h1,
    PTU_CLK_UNUSED = 2'h2,
    PTU_CLK_XTAL = 2'h3
  } ptu_clksel_t;
  typedef enum logic [1:0] {
    PTU_FN_CAPTURE = 2'h0,
    PTU_FN_COMPARE = 2'h1,
    PTU_FN_EPWM = 2'h3,
    PTU_FN_CENTER_ALIGNED_PWM = 2'h2
  } ptu_chfn_t;
endpackage

// ==== rtl/ptu_ch_if.sv ====
// Time base and register path between the timer core and one channel
`timescale 1ns/1ps
interface ptu_ch_if;
  logic [15:0] cnt;
  logic adv;
  logic wrap;
  logic center_aligned_pwm;
  logic ctrl_we;
  logic val_we;
  logic [15:0] wdata;
  logic [1:0] wstrb;
  logic pin_in;
  logic [5:0] ctrl;
  logic [15:0] value;
  logic evt;
  logic pin_out;
  logic pin_drive;
  modport timer (output cnt, adv, wrap, center_aligned_pwm, ctrl_we, val_we, wdata, wstrb, pin_in,
    input ctrl, value, evt, pin_out, pin_drive);
  modport chan (input cnt, adv, wrap, center_aligned_pwm, ctrl_we, val_we, wdata, wstrb, pin_in,
    output ctrl, value, evt, pin_out, pin_drive);
endinterface

// ==== rtl/ptu_channel.sv ====
// One timer channel: input capture, output compare, edge or center PWM
`timescale 1ns/1ps
`include "ptu_defs.svh"
module ptu_channel (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  ptu_ch_if.chan bus
);
  import ptu_pkg::*;
  logic [5:0] ctrl;
  logic [15:0] value;
  logic [15:0] buf_val;
  logic pin_d;
  logic out;
  logic [1:0] edge_sel;
  logic [1:0] mode;
  ptu_chfn_t fn;
  logic rise;
  logic fall;
  logic cap_hit;
  logic match;
  logic pwm_on;
  logic pwm_level;
  logic cmp_level;
  logic next_out;
  logic [15:0] wr_val;

  assign edge_sel = ctrl[`PTU_CH_EDGE_HI:`PTU_CH_EDGE_LO];
  assign mode = ctrl[`PTU_CH_MODE_HI:`PTU_CH_MODE_LO];
  // Global center mode overrides each channel mode
  assign fn = bus.center_aligned_pwm ? PTU_FN_CENTER_ALIGNED_PWM : mode[1] ? PTU_FN_EPWM :
    mode[0] ? PTU_FN_COMPARE : PTU_FN_CAPTURE;
  assign rise = bus.pin_in & ~pin_d;
  assign fall = ~bus.pin_in & pin_d;
  assign cap_hit = (fn == PTU_FN_CAPTURE) && ((edge_sel[0] && rise) || (edge_sel[1] && fall));
  assign match = bus.adv && (bus.cnt == value);
  assign pwm_on = (fn == PTU_FN_EPWM) || (fn == PTU_FN_CENTER_ALIGNED_PWM);
  assign pwm_level = (bus.cnt < value) ^ edge_sel[0];
  assign cmp_level = (edge_sel == 2'h1) ? ~out : edge_sel[0];
  assign next_out = pwm_on ? pwm_level : ((fn == PTU_FN_COMPARE) && match) ? cmp_level : out;
  assign wr_val = {bus.wstrb[1] ? bus.wdata[15:8] : buf_val[15:8],
    bus.wstrb[0] ? bus.wdata[7:0] : buf_val[7:0]};
  assign bus.evt = cap_hit || (match && fn != PTU_FN_CAPTURE);
  assign bus.ctrl = ctrl;
  assign bus.value = value;
  assign bus.pin_out = out;
  // Pin is left to the port when no output action is chosen
  assign bus.pin_drive = (fn != PTU_FN_CAPTURE) && (edge_sel != 2'h0);

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl <= `PTU_CH_RST;
      pin_d <= 1'b0;
      out <= 1'b0;
    end else if (ce) begin
      if (bus.ctrl_we) begin
        ctrl <= bus.wdata[5:0];
      end
      pin_d <= bus.pin_in;
      out <= next_out;
    end
  end

  // PWM duty takes effect as the counter leaves the modulo value (wrap, or turn in center PWM), so no glitch
  always_ff @(posedge clk) begin
    if (rst) begin
      value <= `PTU_CNT_RST;
      buf_val <= `PTU_CNT_RST;
    end else if (ce) begin
      if (bus.val_we) begin
        buf_val <= wr_val;
      end
      if (bus.val_we && !pwm_on) begin
        value <= wr_val;
      end else if (cap_hit) begin
        value <= bus.cnt;
      end else if (pwm_on && bus.wrap) begin
        value <= buf_val;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);
  AST_CAPTURE_VALUE: assert property (cap_hit && !bus.val_we |=> value == $past(bus.cnt))
    else $error("capture did not latch the counter");
  AST_PWM_POLARITY: assert property (pwm_on && $stable(ctrl) |=> out == $past(pwm_level))
    else $error("pwm pin level wrong for polarity");
  AST_COMPARE_SET: assert property ((fn == PTU_FN_COMPARE) && match && edge_sel == 2'h3 |=> out)
    else $error("compare set action missing");
endmodule

// ==== rtl/ptu_top.sv ====
// Two-channel pulse timer unit with AXI4-Lite register access
// Behaviour
// - Two channels, each capture, compare or buffered edge PWM on its own.
// - Clock select: 00 off, 01 bus clock, 10 unused, 11 crystal derived.
// - Prescaler divides the chosen clock by 1 to 128 in powers of two.
// - 16-bit counter counts up, or up and down in center PWM.
// - Modulo bounds the count; 0x0000 or 0xFFFF means full range.
// - Counter reads never disturb counting.
// - Any write to either counter byte clears the counter.
// - The 16-bit counter is the shared time base of all channels.
// - One interrupt per channel plus one for terminal count.
// - Capture triggers on rising, falling or either edge.
// - Compare match sets, clears or toggles the pin.
// - PWM active level is selectable high or low.
// - One global bit puts all channels in center aligned PWM.
// - Route bit feeds channel zero from its pin or the slow oscillator.
// - Crystal derived 500 kHz clock is the external clock choice.
// - Crystal derived clock is synchronised before the prescaler.
// - Overflow flag sets when the counter leaves the modulo value.
// - Flag clears by read while set then write 0; overflow restarts this.
`timescale 1ns/1ps
`include "ptu_defs.svh"
module ptu_top (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic [`PTU_AXI_AW-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`PTU_AXI_AW-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [`PTU_NCH-1:0] CH_PIN_IN,
  output logic [`PTU_NCH-1:0] CH_PIN_OUT,
  output logic [`PTU_NCH-1:0] CH_PIN_OE_N,
  input wire logic SLOW_OSCILLATOR_IN,
  input wire logic CRYSTAL_DERIVED_CLOCK_IN,
  output logic IRQ
);
  import ptu_pkg::*;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic xtal_s1;
  logic xtal_s2;
  logic xtal_s3;
  logic slow_s1;
  logic slow_s2;
  logic [`PTU_NCH-1:0] pin_s1;
  logic [`PTU_NCH-1:0] pin_s2;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      {xtal_s1, xtal_s2, xtal_s3} <= 3'h0;
      {slow_s1, slow_s2} <= 2'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
    end else if (CE) begin
      xtal_s1 <= CRYSTAL_DERIVED_CLOCK_IN;
      xtal_s2 <= xtal_s1;
      xtal_s3 <= xtal_s2;
      slow_s1 <= SLOW_OSCILLATOR_IN;
      slow_s2 <= slow_s1;
      pin_s1 <= CH_PIN_IN;
      pin_s2 <= pin_s1;
    end
  end

  // ****************************************
  // Bus slave
  // ****************************************
  logic aw_held;
  logic w_held;
  logic [`PTU_AXI_AW-1:0] w_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic rd_fire;
  logic [`PTU_AXI_AW-1:0] r_addr;
  logic wr_ok;
  logic rd_ok;
  logic [31:0] rd_data;

  // Write lands one cycle after both halves are held
  assign wr_fire = aw_held && w_held && !S_AXI_BVALID;
  assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
  assign r_addr = S_AXI_ARADDR;
  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      w_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else if (CE) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held <= 1'b1;
        w_addr <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `PTU_RESP_OKAY;
      S_AXI_RVALID <= 1'b0;
      S_AXI_RRESP <= `PTU_RESP_OKAY;
      S_AXI_RDATA <= 32'h0;
    end else if (CE) begin
      if (wr_fire) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_ok ? `PTU_RESP_OKAY : `PTU_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
      if (rd_fire) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP <= rd_ok ? `PTU_RESP_OKAY : `PTU_RESP_SLVERR;
        S_AXI_RDATA <= rd_ok ? rd_data : 32'h0;
      end else if (S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  logic center_aligned_pwm;
  logic [1:0] clk_sel;
  logic [2:0] ps;
  logic [15:0] modv;
  logic route_sel;
  logic [`PTU_INT_W-1:0] int_mask;
  logic [`PTU_INT_W-1:0] int_status;
  logic [`PTU_INT_W-1:0] next_int_status;
  logic ovf_flag;
  logic clr_armed;
  logic wr_sc;
  logic wr_cnt;
  logic wr_mod;
  logic wr_sopt;
  logic wr_imask;
  logic rd_sc;
  logic rd_istat;
  logic ovf_clear;
  logic [15:0] mod_merged;
  logic [`PTU_NCH-1:0] ch_evt;

  assign wr_sc = wr_fire && w_addr == `PTU_OFS_SC && w_strb[0];
  assign wr_cnt = wr_fire && w_addr == `PTU_OFS_CNT && (w_strb[1:0] != 2'h0);
  assign wr_mod = wr_fire && w_addr == `PTU_OFS_MOD;
  assign wr_sopt = wr_fire && w_addr == `PTU_OFS_SOPT && w_strb[0];
  assign wr_imask = wr_fire && w_addr == `PTU_OFS_IMASK && w_strb[0];
  assign rd_sc = rd_fire && r_addr == `PTU_OFS_SC;
  assign rd_istat = rd_fire && r_addr == `PTU_OFS_ISTAT;
  assign mod_merged = {w_strb[1] ? w_data[15:8] : modv[15:8], w_strb[0] ? w_data[7:0] : modv[7:0]};
  assign ovf_clear = wr_sc && clr_armed && !w_data[`PTU_SC_OVF];

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      {center_aligned_pwm, clk_sel, ps} <= `PTU_SC_RST;
      modv <= `PTU_MOD_RST;
      route_sel <= 1'b0;
      int_mask <= `PTU_INT_RST;
    end else if (CE) begin
      if (wr_sc) begin
        {center_aligned_pwm, clk_sel, ps} <= w_data[`PTU_SC_CENTER_ALIGNED_PWM:0];
      end
      if (wr_mod) begin
        modv <= mod_merged;
      end
      if (wr_sopt) begin
        route_sel <= w_data[0];
      end
      if (wr_imask) begin
        int_mask <= w_data[`PTU_INT_W-1:0];
      end
    end
  end

  // ****************************************
  // Clock source, prescaler and counter
  // ****************************************
  logic src_tick;
  logic [6:0] presc;
  logic [6:0] ps_mask;
  logic tick;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic up;
  logic next_up;
  logic ovf_evt;
  logic [15:0] limit;
  logic at_top;

  // Crystal clock is counted by its edges, so it must stay below half the core rate
  assign src_tick = (clk_sel == PTU_CLK_BUS) ? 1'b1 :
    (clk_sel == PTU_CLK_XTAL) ? (xtal_s2 && !xtal_s3) : 1'b0;
  assign ps_mask = 7'((8'h01 << ps) - 8'h01);
  assign tick = src_tick && ((presc & ps_mask) == ps_mask);
  assign limit = (modv == 16'h0000 || modv == `PTU_FULL_RANGE) ? `PTU_FULL_RANGE : modv;
  assign at_top = cnt == limit;

  always_comb begin
    next_cnt = cnt;
    next_up = up;
    ovf_evt = 1'b0;
    if (wr_cnt) begin
      next_cnt = `PTU_CNT_RST;
      next_up = 1'b1;
    end else if (tick && !center_aligned_pwm) begin
      next_cnt = at_top ? 16'h0000 : cnt + 16'h0001;
      ovf_evt = at_top;
    end else if (tick && up) begin
      next_cnt = at_top ? cnt - 16'h0001 : cnt + 16'h0001;
      next_up = !at_top;
      ovf_evt = at_top;
    end else if (tick) begin
      next_cnt = (cnt == 16'h0000) ? 16'h0001 : cnt - 16'h0001;
      next_up = cnt == 16'h0000;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      presc <= 7'h00;
      cnt <= `PTU_CNT_RST;
      up <= 1'b1;
    end else if (CE) begin
      presc <= wr_cnt ? 7'h00 : src_tick ? presc + 7'h01 : presc;
      cnt <= next_cnt;
      up <= next_up;
    end
  end

  // ****************************************
  // Overflow flag and interrupts
  // ****************************************
  assign next_int_status = {ovf_evt, ch_evt} | (rd_istat ? `PTU_INT_RST : int_status);
  assign IRQ = |(int_status & int_mask);

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ovf_flag <= 1'b0;
      clr_armed <= 1'b0;
      int_status <= `PTU_INT_RST;
    end else if (CE) begin
      ovf_flag <= ovf_evt || (ovf_flag && !ovf_clear);
      clr_armed <= !ovf_evt && !wr_sc && (clr_armed || (rd_sc && ovf_flag));
      int_status <= next_int_status;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  logic [5:0] ch_ctrl [`PTU_NCH];
  logic [15:0] ch_value [`PTU_NCH];

  for (genvar i = 0; i < `PTU_NCH; i++) begin : g_ch
    ptu_ch_if chb ();
    logic [7:0] sc_addr;
    assign sc_addr = 8'(`PTU_OFS_CH0SC + `PTU_CH_STRIDE * i);
    assign chb.cnt = cnt;
    assign chb.adv = tick && !wr_cnt;
    assign chb.wrap = ovf_evt;
    assign chb.center_aligned_pwm = center_aligned_pwm;
    assign chb.ctrl_we = wr_fire && w_addr == sc_addr && w_strb[0];
    assign chb.val_we = wr_fire && w_addr == sc_addr + 8'h04 && (w_strb[1:0] != 2'h0);
    assign chb.wdata = w_data[15:0];
    assign chb.wstrb = w_strb[1:0];
    assign chb.pin_in = (i == 0 && route_sel) ? slow_s2 : pin_s2[i];
    ptu_channel u_ch (
      .clk(CORE_CLK),
      .rst(RST),
      .ce(CE),
      .bus(chb)
    );
    assign ch_ctrl[i] = chb.ctrl;
    assign ch_value[i] = chb.value;
    assign ch_evt[i] = chb.evt;
    assign CH_PIN_OUT[i] = chb.pin_out;
    assign CH_PIN_OE_N[i] = !chb.pin_drive;
  end

  // ****************************************
  // Write and read address decode, read data
  // ****************************************
  assign wr_ok = w_addr == `PTU_OFS_SC || w_addr == `PTU_OFS_CNT || w_addr == `PTU_OFS_MOD ||
    w_addr == `PTU_OFS_SOPT || w_addr == `PTU_OFS_IMASK || w_addr == `PTU_OFS_ISTAT ||
    (w_addr >= `PTU_OFS_CH0SC && w_addr < `PTU_OFS_ISTAT && w_addr[1:0] == 2'h0);
  assign rd_ok = r_addr == `PTU_OFS_SC || r_addr == `PTU_OFS_CNT || r_addr == `PTU_OFS_MOD ||
    r_addr == `PTU_OFS_SOPT || r_addr == `PTU_OFS_IMASK || r_addr == `PTU_OFS_ISTAT ||
    (r_addr >= `PTU_OFS_CH0SC && r_addr < `PTU_OFS_ISTAT && r_addr[1:0] == 2'h0);
  // Counter read has no side effect on counting
  assign rd_data = (r_addr == `PTU_OFS_SC) ? {24'h0, ovf_flag, 1'b0, center_aligned_pwm, clk_sel, ps} :
    (r_addr == `PTU_OFS_CNT) ? {16'h0, cnt} :
    (r_addr == `PTU_OFS_MOD) ? {16'h0, modv} :
    (r_addr == `PTU_OFS_SOPT) ? {31'h0, route_sel} :
    (r_addr == `PTU_OFS_ISTAT) ? {29'h0, int_status} :
    (r_addr == `PTU_OFS_IMASK) ? {29'h0, int_mask} :
    (r_addr[2] == 1'b0) ? {24'h0, int_status[r_addr[3]], 1'b0, ch_ctrl[r_addr[3]]} :
    {16'h0, ch_value[r_addr[3]]};

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST || !CE);

  sequence s_clear_write;
    clr_armed && wr_sc && !w_data[`PTU_SC_OVF] && !ovf_evt;
  endsequence
  sequence s_arm;
    rd_sc && ovf_flag && !ovf_evt && !wr_sc;
  endsequence

  AST_DISABLED_HOLD: assert property (clk_sel == PTU_CLK_OFF && !wr_cnt |=> $stable(cnt))
    else $error("counter moved with no clock source");
  AST_PRESCALE_GATE: assert property (tick |-> src_tick && (presc & ps_mask) == ps_mask)
    else $error("counter advanced off the prescaler tap");
  AST_UP_STEP: assert property (tick && !center_aligned_pwm && !at_top && !wr_cnt |=> cnt == $past(cnt) + 16'h0001)
    else $error("up count step wrong");
  AST_WRAP_ZERO: assert property (tick && !center_aligned_pwm && at_top && !wr_cnt |=> cnt == 16'h0000 && ovf_flag)
    else $error("no wrap to zero at modulo");
  AST_FULL_RANGE: assert property (modv == 16'h0000 |-> limit == `PTU_FULL_RANGE)
    else $error("zero modulo not free running");
  AST_CENTER_TURN: assert property (tick && center_aligned_pwm && up && at_top && !wr_cnt |=> !up && cnt == $past(cnt) - 16'h0001)
    else $error("center count did not turn at modulo");
  AST_READ_QUIET: assert property (rd_fire && r_addr == `PTU_OFS_CNT && !tick && !wr_cnt |=> $stable(cnt))
    else $error("counter read disturbed count");
  AST_CNT_CLEAR: assert property (wr_cnt |=> cnt == 16'h0000)
    else $error("counter write did not clear");
  AST_FLAG_ARM: assert property (s_arm |=> clr_armed)
    else $error("status read did not arm flag clear");
  AST_FLAG_CLEAR_SEQ: assert property (s_clear_write |=> !ovf_flag)
    else $error("overflow flag clear sequence failed");
  AST_FLAG_SET_WINS: assert property (ovf_evt |=> ovf_flag && int_status[`PTU_INT_OVF])
    else $error("overflow event lost");
  AST_IRQ_RAISE: assert property (ch_evt[0] && int_mask[0] |=> IRQ)
    else $error("channel event did not raise interrupt");
endmodule

// ==== dv/ptu_pin_model.sv ====
// Pin side model: channel wires, slow oscillator and crystal clock
`timescale 1ns/1ps
module ptu_pin_model (
  input wire logic clk,
  input wire logic [1:0] drv,
  input wire logic osc,
  input wire logic xtal_on,
  input wire logic [1:0] pin_out,
  input wire logic [1:0] pin_oe_n,
  output logic [1:0] pin_in,
  output logic slow_osc,
  output logic xtal,
  output int hi_cnt
);
  // Driven pins read back the device level, released ones the board level
  assign pin_in = (pin_out & ~pin_oe_n) | (drv & pin_oe_n);
  assign slow_osc = osc;
  // Odd start offset keeps the 500 kHz edges off the core clock edges
  initial begin
    xtal = 1'h0;
    #3;
    forever #1000 xtal = xtal_on ? ~xtal : 1'h0;
  end
  initial hi_cnt = 0;
  always @(posedge clk) if (!pin_oe_n[1] && pin_out[1]) hi_cnt <= hi_cnt + 1;
endmodule

// ==== dv/testbench.sv ====
// Self-checking bench for the pulse timer unit over its register bus
`timescale 1ns/1ps
`include "ptu_defs.svh"
module testbench;
  localparam logic [7:0] CH1SC = `PTU_OFS_CH0SC + 8'(`PTU_CH_STRIDE);
  localparam logic [7:0] CH1V = `PTU_OFS_CH0V + 8'(`PTU_CH_STRIDE);
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic bready = 1'h0;
  logic arvalid = 1'h0;
  logic rready = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] drv = 2'h0;
  logic osc = 1'h0;
  logic xtal_on = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, slow_osc, xtal;
  logic [1:0] bresp, rresp, pin_in, pin_out, pin_oe_n, r;
  logic [31:0] rdata, d, t;
  int hi_cnt, h0;
  int n_fail = 0;
  int comparisons = 0;

  always #5 clk = ~clk;

  ptu_top i_ptu_top (.CORE_CLK(clk), .RST(rst), .CE(1'h1),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .CH_PIN_IN(pin_in), .CH_PIN_OUT(pin_out), .CH_PIN_OE_N(pin_oe_n),
    .SLOW_OSCILLATOR_IN(slow_osc), .CRYSTAL_DERIVED_CLOCK_IN(xtal), .IRQ(irq));

  ptu_pin_model i_ptu_pin_model (.clk(clk), .drv(drv), .osc(osc), .xtal_on(xtal_on),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in), .slow_osc(slow_osc),
    .xtal(xtal), .hi_cnt(hi_cnt));

  // ****************************************
  // Checks and bus cycles
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chkr(input string n, input int lo, input int hi, input logic [31:0] g);
    comparisons++;
    if ((^g === 1'bx) || g < lo || g > hi) begin
      n_fail++;
      $display("MISMATCH %s expected %0d to %0d seen %h", n, lo, hi, g);
    end
  endtask

  // Ready is sampled mid-cycle; inputs only move after rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    b = 1'h0;
    @(posedge clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!b) begin
      @(negedge clk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      r = bresp;
      @(posedge clk);
      if (aw) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ar, k;
    k = 1'h0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!k) begin
      @(negedge clk);
      ar = arvalid && arready;
      k = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ar) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask

  task automatic print_verdict;
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    rd(`PTU_OFS_SC);
    chk("sc reset", 32'h0, d);
    chk("sc rd resp", 32'h0, {30'h0, r});
    rd(`PTU_OFS_CNT);
    chk("cnt reset", 32'h0, d);
    chk("oe reset", 32'h3, {30'h0, pin_oe_n});
    wr(8'h30, 32'h5);
    chk("bad wr resp", 32'h2, {30'h0, r});
    rd(8'h30);
    chk("bad rd resp", 32'h2, {30'h0, r});
    chk("bad rd data", 32'h0, d);
    for (int s = 0; s < 3; s += 2) begin
      wr(`PTU_OFS_SC, 32'(s << 3));
      repeat (50) @(posedge clk);
      rd(`PTU_OFS_CNT);
      chk("cnt stopped", 32'h0, d);
    end
    // Modulo 0 and 0xFFFF both give the full range
    for (int p = 0; p < 8; p++) begin
      wr(`PTU_OFS_MOD, p[0] ? 32'hFFFF : 32'h0);
      wr(`PTU_OFS_SC, 32'h08 | p);
      wr(`PTU_OFS_CNT, 32'h1234);
      repeat (256) @(posedge clk);
      rd(`PTU_OFS_CNT);
      chkr("prescaled cnt", 256 >> p, (256 >> p) + (8 >> p) + 1, d);
    end
    rd(`PTU_OFS_CNT);
    t = d;
    rd(`PTU_OFS_CNT);
    chkr("cnt after read", t, t + 1, d);
    wr(`PTU_OFS_CNT, 32'hBEEF);
    chk("cnt wr resp", 32'h0, {30'h0, r});
    rd(`PTU_OFS_CNT);
    chk("cnt cleared", 32'h0, d);
    wr(`PTU_OFS_MOD, 32'h9);
    wr(`PTU_OFS_SC, 32'h08);
    for (int i = 0; i < 6; i++) begin
      rd(`PTU_OFS_CNT);
      chkr("cnt in modulo", 0, 9, d);
    end
    // Overflow every 512 cycles from here
    wr(`PTU_OFS_MOD, 32'h3);
    wr(`PTU_OFS_SC, 32'h0F);
    wr(`PTU_OFS_CNT, 32'h0);
    wr(`PTU_OFS_IMASK, 32'h4);
    rd(`PTU_OFS_ISTAT);
    chk("irq after clear", 32'h0, {31'h0, irq});
    for (int i = 0; i < 600 && irq !== 1'h1; i++) @(posedge clk);
    chk("irq on wrap", 32'h1, {31'h0, irq});
    wr(`PTU_OFS_SC, 32'h0F);
    rd(`PTU_OFS_SC);
    chk("flag unarmed", 32'h8F, d);
    wr(`PTU_OFS_SC, 32'h0F);
    rd(`PTU_OFS_SC);
    chk("flag cleared", 32'h0F, d);
    rd(`PTU_OFS_ISTAT);
    chk("wrap status", 32'h4, d);
    rd(`PTU_OFS_ISTAT);
    chk("status read clr", 32'h0, d);
    wr(`PTU_OFS_IMASK, 32'h0);
    repeat (600) @(posedge clk);
    chk("masked irq", 32'h0, {31'h0, irq});
    rd(`PTU_OFS_ISTAT);
    chk("masked status", 32'h4, d & 32'h4);
    // Compare: set, clear, then toggle once per wrap
    wr(`PTU_OFS_CH0V, 32'h2);
    for (int m = 3; m > 1; m--) begin
      wr(`PTU_OFS_CH0SC, 32'h10 | (m << 2));
      repeat (600) @(posedge clk);
      chk("compare pin", 32'(m - 2), {31'h0, pin_out[0]});
    end
    chk("compare drives", 32'h0, {31'h0, pin_oe_n[0]});
    wr(`PTU_OFS_CH0SC, 32'h14);
    repeat (600) @(posedge clk);
    t = {31'h0, ~pin_out[0]};
    repeat (512) @(posedge clk);
    chk("toggle pin", t, {31'h0, pin_out[0]});
    wr(`PTU_OFS_IMASK, 32'h1);
    chk("channel irq", 32'h1, {31'h0, irq});
    rd(`PTU_OFS_ISTAT);
    chk("compare flag", 32'h1, d & 32'h1);
    // PWM on channel 1, period 4 then 6 in center mode
    wr(`PTU_OFS_SC, 32'h08);
    wr(CH1V, 32'h1);
    for (int k = 0; k < 3; k++) begin
      if (k < 2) wr(CH1SC, k ? 32'h24 : 32'h28);
      else wr(`PTU_OFS_SC, 32'h28);
      repeat (20) @(posedge clk);
      h0 = hi_cnt;
      repeat (400) @(posedge clk);
      if (k == 0) chkr("pwm high", 96, 104, hi_cnt - h0);
      if (k == 1) chkr("pwm low", 296, 304, hi_cnt - h0);
      if (k == 2) chkr("center pwm", 328, 338, hi_cnt - h0);
    end
    // Capture on channel 0 pin, 128 cycles a count
    wr(`PTU_OFS_MOD, 32'h0);
    wr(`PTU_OFS_SC, 32'h0F);
    for (int e = 3; e > 0; e--) begin
      wr(`PTU_OFS_CNT, 32'h0);
      wr(`PTU_OFS_CH0SC, 32'(e << 2));
      repeat (320) @(posedge clk);
      drv[0] <= 1'h1;
      repeat (10) @(posedge clk);
      rd(`PTU_OFS_CH0V);
      chk("capture rise", (e == 2) ? 32'h5 : 32'h2, d);
      repeat (320) @(posedge clk);
      drv[0] <= 1'h0;
      repeat (10) @(posedge clk);
      rd(`PTU_OFS_CH0V);
      chk("capture fall", (e == 1) ? 32'h2 : 32'h5, d);
    end
    wr(`PTU_OFS_SOPT, 32'h1);
    wr(`PTU_OFS_CNT, 32'h0);
    repeat (200) @(posedge clk);
    drv[0] <= 1'h1;
    repeat (250) @(posedge clk);
    osc <= 1'h1;
    repeat (10) @(posedge clk);
    rd(`PTU_OFS_CH0V);
    chk("slow osc capture", 32'h3, d);
    xtal_on <= 1'h1;
    wr(`PTU_OFS_SC, 32'h18);
    wr(`PTU_OFS_CNT, 32'h0);
    repeat (2000) @(posedge clk);
    rd(`PTU_OFS_CNT);
    chkr("crystal count", 9, 11, d);
    print_verdict();
  end

  // A hung handshake ends here
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule
